// [afc_cfg.svh]
// Constants for the output data format control block.
// Included by the lane and top design files and by the bench; definitions only.
`ifndef AFC_CFG_SVH
`define AFC_CFG_SVH

// --------------------------------------------------------------------
// Register addresses and reset values
// --------------------------------------------------------------------
`define AFC_ADDR_RESET      7'h00
`define AFC_ADDR_FORMAT     7'h04
`define AFC_FORMAT_RESET    8'h00
`define AFC_READ_EMPTY      8'h00

// --------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------
`define AFC_RESET_BIT       7
`define AFC_PAT_MSB         7
`define AFC_PAT_LSB         5
`define AFC_ABP_BIT         4
`define AFC_TEST_BIT        2
`define AFC_SCRAMBLE_BIT    1
`define AFC_SIGNED_BIT      0

// --------------------------------------------------------------------
// Serial word layout
// --------------------------------------------------------------------
`define AFC_CNT_ZERO        5'h00
`define AFC_CNT_ADDR_LAST   5'h07
`define AFC_CNT_DATA_FIRST  5'h08
`define AFC_CNT_WORD_LAST   5'h0F

// --------------------------------------------------------------------
// Test pattern codes and output masks
// --------------------------------------------------------------------
`define AFC_PAT_ZEROS       3'h1
`define AFC_PAT_ONES        3'h3
`define AFC_PAT_CHECKER     3'h4
`define AFC_PAT_TOGGLE      3'h5
`define AFC_WORD_ZEROS      13'h0000
`define AFC_WORD_ONES       13'h1FFF
`define AFC_WORD_CHECK_HI   13'h1555
`define AFC_WORD_CHECK_LO   13'h0AAA
`define AFC_ABP_MASK        12'hAAA

`endif

// [afc_pkg.sv]
// Types shared by the output data format control block.
// Assumes afc_cfg.svh is on the include path.
package afc_pkg;

  localparam int AFC_DATA_W = 12;

  typedef enum logic [1:0] {AFC_IDLE, AFC_SHIFT, AFC_HOLD} afc_sp_state_t;

  typedef struct packed {
    logic [3:0]    sync1;
    logic [3:0]    sync2;
    logic          sck_prev;
    afc_sp_state_t state;
    logic [4:0]    bit_cnt;
    logic [15:0]   shift;
    logic          is_read;
    logic [7:0]    rd_data;
    logic          sdo_low;
    logic [7:0]    format;
    logic          phase;
  } afc_top_t;

  typedef struct packed {
    logic [AFC_DATA_W:0] word;
  } afc_lane_t;

endpackage

// [afc_fmt_lane.sv]
// One output channel: coding, scrambling, polarity and test patterns.
// Assumes sample inputs and settings are on the MCLK_I domain.
`timescale 1ns/1ns
`include "afc_cfg.svh"

module afc_fmt_lane
  import afc_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic [AFC_DATA_W-1:0] data_i,
  input  wire logic                  ovr_i,
  input  wire logic [2:0]            pattern_i,
  input  wire logic                  test_en_i,
  input  wire logic                  scramble_i,
  input  wire logic                  abp_i,
  input  wire logic                  signed_i,
  input  wire logic                  phase_i,
  output logic      [AFC_DATA_W-1:0] data_o,
  output logic                       ovr_o
);

  afc_lane_t lane_reg;
  afc_lane_t lane_next;

  // ------------------------------------------------------------------
  // Word transform
  // ------------------------------------------------------------------
  always_comb begin
    logic [AFC_DATA_W:0] w;
    w = {ovr_i, data_i};
    if (signed_i) begin
      w[AFC_DATA_W-1] = ~w[AFC_DATA_W-1];
    end
    if (scramble_i) begin
      w[AFC_DATA_W-1:1] = w[AFC_DATA_W-1:1] ^ {(AFC_DATA_W-1){w[0]}};
    end
    if (abp_i) begin
      w[AFC_DATA_W-1:0] = w[AFC_DATA_W-1:0] ^ `AFC_ABP_MASK;
    end
    if (test_en_i) begin
      case (pattern_i)
        `AFC_PAT_ZEROS: begin
          w = `AFC_WORD_ZEROS;
        end
        `AFC_PAT_ONES: begin
          w = `AFC_WORD_ONES;
        end
        `AFC_PAT_CHECKER: begin
          w = phase_i ? `AFC_WORD_CHECK_HI : `AFC_WORD_CHECK_LO;
        end
        `AFC_PAT_TOGGLE: begin
          w = phase_i ? `AFC_WORD_ONES : `AFC_WORD_ZEROS;
        end
        default: begin
          w = `AFC_WORD_ZEROS;
        end
      endcase
    end
    lane_next.word = w;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lane_reg <= '0;
    end else begin
      lane_reg <= lane_next;
    end
  end

  assign data_o = lane_reg.word[AFC_DATA_W-1:0];
  assign ovr_o  = lane_reg.word[AFC_DATA_W];

endmodule

// [afc_fmt_ctrl.sv]
// Output data format control: serial configuration slave and two lanes.
// Assumes SCK_I is slow against MCLK_I (at least 4 MCLK periods per
// SCK half period) and converter samples arrive on MCLK_I.
`timescale 1ns/1ns
`include "afc_cfg.svh"

module afc_fmt_ctrl
  import afc_pkg::*;
(
  input  wire logic                  MCLK_I,
  input  wire logic                  RESET_N_I,
  input  wire logic                  PROGRAMMING_PORT_SELECT_I,
  input  wire logic                  CS_N_I,
  input  wire logic                  SCK_I,
  input  wire logic                  SDI_I,
  output logic                       SDO_O,
  output logic                       SDO_OE_O,
  input  wire logic [AFC_DATA_W-1:0] CH_A_DATA_I,
  input  wire logic                  CH_A_OVR_I,
  input  wire logic [AFC_DATA_W-1:0] CH_B_DATA_I,
  input  wire logic                  CH_B_OVR_I,
  output logic      [AFC_DATA_W-1:0] CH_A_DATA_O,
  output logic                       CH_A_OVR_O,
  output logic      [AFC_DATA_W-1:0] CH_B_DATA_O,
  output logic                       CH_B_OVR_O,
  output logic      [7:0]            FORMAT_REG_O
);

  afc_top_t top_reg;
  afc_top_t top_next;

  // ------------------------------------------------------------------
  // Serial port and register bank
  // ------------------------------------------------------------------
  always_comb begin
    logic       cs_n;
    logic       sck;
    logic       sdi;
    logic       par_mode;
    logic       rise;
    logic       fall;
    logic [6:0] addr;
    logic [7:0] data;
    cs_n     = top_reg.sync2[0];
    sck      = top_reg.sync2[1];
    sdi      = top_reg.sync2[2];
    par_mode = top_reg.sync2[3];
    rise     = sck & ~top_reg.sck_prev;
    fall     = ~sck & top_reg.sck_prev;
    addr     = '0;
    data     = '0;

    top_next          = top_reg;
    top_next.sync1    = {PROGRAMMING_PORT_SELECT_I, SDI_I, SCK_I, CS_N_I};
    top_next.sync2    = top_reg.sync1;
    top_next.sck_prev = sck;
    top_next.phase    = ~top_reg.phase;

    case (top_reg.state)
      AFC_IDLE: begin
        top_next.sdo_low = 1'b0;
        if (!cs_n && !par_mode) begin
          top_next.state   = AFC_SHIFT;
          top_next.bit_cnt = `AFC_CNT_ZERO;
        end
      end
      AFC_SHIFT: begin
        if (cs_n || par_mode) begin
          top_next.state   = AFC_IDLE;
          top_next.sdo_low = 1'b0;
        end else if (rise) begin
          top_next.shift   = {top_reg.shift[14:0], sdi};
          top_next.bit_cnt = top_reg.bit_cnt + 5'h01;
          if (top_reg.bit_cnt == `AFC_CNT_ZERO) begin
            top_next.is_read = sdi;
          end
          if (top_reg.bit_cnt == `AFC_CNT_ADDR_LAST) begin
            addr = {top_reg.shift[5:0], sdi};
            if (addr == `AFC_ADDR_FORMAT) begin
              top_next.rd_data = top_reg.format;
            end else begin
              top_next.rd_data = `AFC_READ_EMPTY;
            end
          end
          if (top_reg.bit_cnt == `AFC_CNT_WORD_LAST) begin
            top_next.state = AFC_HOLD;
            addr = top_reg.shift[13:7];
            data = {top_reg.shift[6:0], sdi};
            if (!top_reg.is_read) begin
              if (addr == `AFC_ADDR_RESET && data[`AFC_RESET_BIT]) begin
                top_next.format = `AFC_FORMAT_RESET;
              end else if (addr == `AFC_ADDR_FORMAT) begin
                top_next.format = data;
              end
            end
          end
        end else if (fall && top_reg.is_read &&
                     top_reg.bit_cnt >= `AFC_CNT_DATA_FIRST) begin
          top_next.sdo_low = ~top_reg.rd_data[7];
          top_next.rd_data = {top_reg.rd_data[6:0], 1'b0};
        end
      end
      AFC_HOLD: begin
        // Edges past the sixteenth are ignored
        if (cs_n || par_mode) begin
          top_next.state   = AFC_IDLE;
          top_next.sdo_low = 1'b0;
        end
      end
      default: begin
        top_next.state   = AFC_IDLE;
        top_next.sdo_low = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      top_reg        <= '0;
      top_reg.sync1  <= 4'h1;
      top_reg.sync2  <= 4'h1;
      top_reg.state  <= AFC_IDLE;
      top_reg.format <= `AFC_FORMAT_RESET;
    end else begin
      top_reg <= top_next;
    end
  end

  assign SDO_O        = 1'b0;
  assign SDO_OE_O     = top_reg.sdo_low;
  assign FORMAT_REG_O = top_reg.format;

  // ------------------------------------------------------------------
  // Output lanes
  // ------------------------------------------------------------------
  afc_fmt_lane u_lane_a (
    .clk_i      (MCLK_I),
    .rst_n_i    (RESET_N_I),
    .data_i     (CH_A_DATA_I),
    .ovr_i      (CH_A_OVR_I),
    .pattern_i  (top_reg.format[`AFC_PAT_MSB:`AFC_PAT_LSB]),
    .test_en_i  (top_reg.format[`AFC_TEST_BIT]),
    .scramble_i (top_reg.format[`AFC_SCRAMBLE_BIT]),
    .abp_i      (top_reg.format[`AFC_ABP_BIT]),
    .signed_i   (top_reg.format[`AFC_SIGNED_BIT]),
    .phase_i    (top_reg.phase),
    .data_o     (CH_A_DATA_O),
    .ovr_o      (CH_A_OVR_O)
  );

  afc_fmt_lane u_lane_b (
    .clk_i      (MCLK_I),
    .rst_n_i    (RESET_N_I),
    .data_i     (CH_B_DATA_I),
    .ovr_i      (CH_B_OVR_I),
    .pattern_i  (top_reg.format[`AFC_PAT_MSB:`AFC_PAT_LSB]),
    .test_en_i  (top_reg.format[`AFC_TEST_BIT]),
    .scramble_i (top_reg.format[`AFC_SCRAMBLE_BIT]),
    .abp_i      (top_reg.format[`AFC_ABP_BIT]),
    .signed_i   (top_reg.format[`AFC_SIGNED_BIT]),
    .phase_i    (top_reg.phase),
    .data_o     (CH_B_DATA_O),
    .ovr_o      (CH_B_OVR_O)
  );

endmodule

// [afc_fmt_ctrl_props.sv]
// Checker for the format control top module, bound below.
// Assumes one MCLK_I domain and active-low asynchronous reset.
`timescale 1ns/1ns
module afc_fmt_ctrl_props
  import afc_pkg::*;
(
  input wire logic                  MCLK_I,
  input wire logic                  RESET_N_I,
  input wire logic                  PROGRAMMING_PORT_SELECT_I,
  input wire logic                  CS_N_I,
  input wire logic                  SDO_O,
  input wire logic                  SDO_OE_O,
  input wire logic [AFC_DATA_W-1:0] CH_A_DATA_I,
  input wire logic                  CH_A_OVR_I,
  input wire logic [AFC_DATA_W-1:0] CH_B_DATA_I,
  input wire logic [AFC_DATA_W-1:0] CH_A_DATA_O,
  input wire logic                  CH_A_OVR_O,
  input wire logic [AFC_DATA_W-1:0] CH_B_DATA_O,
  input wire logic [7:0]            FORMAT_REG_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  AST_RST_FMT: assert property ($rose(RESET_N_I) |-> FORMAT_REG_O == 8'h00)
    else $error("Format not clear after reset");
  AST_SDO_LOW: assert property (SDO_O == 1'b0)
    else $error("Open-drain value not low");
  AST_OE_IDLE: assert property (CS_N_I [*6] |-> !SDO_OE_O)
    else $error("Readback drive outside frame");
  AST_FMT_CS: assert property ($changed(FORMAT_REG_O) |-> !CS_N_I)
    else $error("Format changed outside frame");
  AST_PAR: assert property (PROGRAMMING_PORT_SELECT_I [*5] |-> $stable(FORMAT_REG_O))
    else $error("Format changed in parallel mode");
  AST_PASS: assert property (FORMAT_REG_O == 8'h00 ##1 FORMAT_REG_O == 8'h00 |->
    CH_A_DATA_O == $past(CH_A_DATA_I) && CH_A_OVR_O == $past(CH_A_OVR_I))
    else $error("Plain data not passed");
  AST_SIGNED: assert property (FORMAT_REG_O == 8'h01 ##1 FORMAT_REG_O == 8'h01 |->
    CH_B_DATA_O == ($past(CH_B_DATA_I) ^ 12'h800))
    else $error("Signed coding wrong");
  AST_SCRAM: assert property (FORMAT_REG_O == 8'h02 ##1 FORMAT_REG_O == 8'h02 |->
    CH_A_DATA_O == ($past(CH_A_DATA_I) ^ {{11{$past(CH_A_DATA_I[0])}}, 1'b0}))
    else $error("Scrambled data wrong");
  AST_ZEROS: assert property ((FORMAT_REG_O & 8'hE4) == 8'h24 [*2] |->
    {CH_A_OVR_O, CH_A_DATA_O} == 13'h0000 && CH_B_DATA_O == 12'h000)
    else $error("Zero pattern wrong");
  AST_ONES: assert property ((FORMAT_REG_O & 8'hE4) == 8'h64 [*2] |->
    {CH_A_OVR_O, CH_A_DATA_O} == 13'h1FFF)
    else $error("Ones pattern wrong");
  AST_TOGGLE: assert property ((FORMAT_REG_O & 8'hE4) == 8'hA4 [*3] |->
    CH_A_DATA_O == ~$past(CH_A_DATA_O) && (CH_A_DATA_O == 12'h000 || CH_A_DATA_O == 12'hFFF))
    else $error("Toggle pattern wrong");
endmodule

bind afc_fmt_ctrl afc_fmt_ctrl_props props_u (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I),
  .PROGRAMMING_PORT_SELECT_I(PROGRAMMING_PORT_SELECT_I), .CS_N_I(CS_N_I), .SDO_O(SDO_O),
  .SDO_OE_O(SDO_OE_O), .CH_A_DATA_I(CH_A_DATA_I), .CH_A_OVR_I(CH_A_OVR_I),
  .CH_B_DATA_I(CH_B_DATA_I), .CH_A_DATA_O(CH_A_DATA_O), .CH_A_OVR_O(CH_A_OVR_O),
  .CH_B_DATA_O(CH_B_DATA_O), .FORMAT_REG_O(FORMAT_REG_O));

// [afc_host_model.sv]
// Host controller model driving the serial configuration port.
// Assumes clk_i is MCLK_I; SCK half period is 6 clocks.
`timescale 1ns/1ns
module afc_host_model (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      sdi_o
);
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    sdi_o  = 1'b0;
  end
  // ------------------------------------------------------------
  // Word transfer, nbits rises, readback sampled before rises 9 to 16
  // ------------------------------------------------------------
  task automatic xfer(input logic [15:0] w, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk_i);
    #1 cs_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      repeat (2) @(posedge clk_i);
      #1 sdi_o = (i < 16) ? w[15-i] : ~sdi_o;
      repeat (4) @(posedge clk_i);
      if (i >= 8 && i <= 15) rd[15-i] = sdo_i;
      #1 sck_o = 1'b1;
      repeat (6) @(posedge clk_i);
      #1 sck_o = 1'b0;
    end
    repeat (6) @(posedge clk_i);
    #1 cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    repeat (6) @(posedge clk_i);
  endtask
endmodule

// [tb.sv]
// Self-checking bench: host model, random samples, reference model.
// Assumes afc_cfg.svh on the include path.
`timescale 1ns/1ns
`include "afc_cfg.svh"
module tb;
  import afc_pkg::*;
  logic        mclk, rst_n, par_sel, sdo, sdo_oe, cs_n, sck, sdi, a_ov, b_ov, a_oq, b_oq;
  logic [11:0] a_d, b_d, a_q, b_q;
  logic [7:0]  fmt_o, shadow, rd, f;
  int          err_count, n_tests, seed;
  logic [7:0]  tbl [13] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h13, 8'h04, 8'h24,
                            8'h44, 8'h64, 8'h84, 8'hA4, 8'hC4, 8'hE4};
  wire         sdo_w = sdo_oe ? sdo : 1'b1;
  afc_fmt_ctrl dut_u (.MCLK_I(mclk), .RESET_N_I(rst_n), .PROGRAMMING_PORT_SELECT_I(par_sel),
    .CS_N_I(cs_n), .SCK_I(sck), .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(sdo_oe),
    .CH_A_DATA_I(a_d), .CH_A_OVR_I(a_ov), .CH_B_DATA_I(b_d), .CH_B_OVR_I(b_ov),
    .CH_A_DATA_O(a_q), .CH_A_OVR_O(a_oq), .CH_B_DATA_O(b_q), .CH_B_OVR_O(b_oq),
    .FORMAT_REG_O(fmt_o));
  afc_host_model host_u (.clk_i(mclk), .sdo_i(sdo_w), .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi));
  // ------------------------------------------------------------
  // Reference model and checks
  // ------------------------------------------------------------
  function automatic logic [12:0] expv(logic [7:0] g, logic [11:0] d, logic o, logic ph);
    logic [11:0] x;
    x = d;
    if (g[0]) x[11] = ~x[11];
    if (g[1]) x[11:1] = x[11:1] ^ {11{x[0]}};
    if (g[4]) x = x ^ 12'hAAA;
    if (!g[2]) return {o, x};
    case (g[7:5])
      3'h3: return 13'h1FFF;
      3'h4: return ph ? 13'h0AAA : 13'h1555;
      3'h5: return ph ? 13'h1FFF : 13'h0000;
      default: return 13'h0000;
    endcase
  endfunction
  task automatic chk(input logic [12:0] got, input logic [12:0] e0, input logic [12:0] e1);
    n_tests++;
    if (got !== e0 && got !== e1) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, e0);
    end
  endtask
  task automatic ckreg(input logic [7:0] got, input logic [7:0] e);
    chk({5'h00, got}, {5'h00, e}, {5'h00, e});
  endtask
  task automatic run(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1 chk({a_oq, a_q}, expv(shadow, a_d, a_ov, 0), expv(shadow, a_d, a_ov, 1));
      chk({b_oq, b_q}, expv(shadow, b_d, b_ov, 0), expv(shadow, b_d, b_ov, 1));
      a_d = 12'($random(seed));
      b_d = 12'($random(seed));
      a_ov = 1'($random(seed));
      b_ov = 1'($random(seed));
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.xfer({1'b0, a, d}, 16, rd);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    host_u.xfer({1'b1, a, 8'h00}, 16, rd);
    ckreg(rd, e);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (90000) @(posedge mclk);
    err_count++;
    $display("[ERR] %0t run timed out", $time);
    report_and_stop;
  end
  initial begin
    seed = 32'h0000B3FC;
    {rst_n, par_sel, a_ov, b_ov, a_d, b_d, shadow} = '0;
    repeat (5) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge mclk);
    ckreg(fmt_o, `AFC_FORMAT_RESET);
    rdchk(`AFC_ADDR_FORMAT, 8'h00);
    for (int i = 0; i < 16; i++) begin
      f = (i < 13) ? tbl[i] : (8'($random(seed)) & 8'hF7);
      wr(`AFC_ADDR_FORMAT, f);
      shadow = f;
      ckreg(fmt_o, shadow);
      rdchk(`AFC_ADDR_FORMAT, shadow);
      run(12);
    end
    wr(7'h05, 8'h5A);
    ckreg(fmt_o, shadow);
    rdchk(7'h05, 8'h00);
    host_u.xfer({1'b0, `AFC_ADDR_FORMAT, 8'h33}, 10, rd);
    ckreg(fmt_o, shadow);
    host_u.xfer({1'b0, `AFC_ADDR_FORMAT, 8'h13}, 18, rd);
    shadow = 8'h13;
    ckreg(fmt_o, shadow);
    run(4);
    #1 par_sel = 1'b1;
    repeat (8) @(posedge mclk);
    wr(`AFC_ADDR_FORMAT, 8'h01);
    ckreg(fmt_o, shadow);
    #1 par_sel = 1'b0;
    repeat (8) @(posedge mclk);
    wr(`AFC_ADDR_RESET, 8'h80);
    shadow = 8'h00;
    ckreg(fmt_o, shadow);
    rdchk(`AFC_ADDR_RESET, 8'h00);
    run(4);
    report_and_stop;
  end
endmodule
